// >>> ssp_slave.v
`include "ssp_map.vh"
`default_nettype none
module ssp_slave #(
   parameter FILT_W = 2
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        sclIn,
   output reg         sclOut,
   output reg         sclOe,
   input  wire        sdaIn,
   output reg         sdaOut,
   output reg         sdaOe,
   output reg         smbusLevels,
   output reg         portIrq
);

   localparam ST_IDLE = 3'd0;
   localparam ST_RECV = 3'd1;
   localparam ST_ACK  = 3'd2;
   localparam ST_SEND = 3'd3;
   localparam ST_MACK = 3'd4;

   reg  [7:0] ctl_r;
   reg  [7:0] stat_r;
   reg  [7:0] pif_r;
   reg  [7:0] pie_r;
   reg  [7:0] gic_r;
   reg  [7:0] addr_r;
   reg  [7:0] buf_r;
   reg  [7:0] sr_r;
   reg  [2:0] st_r;
   reg  [3:0] bitCnt_r;
   reg        ackOk_r;
   reg        matched_r;
   reg  [1:0] addrPhase_r;
   reg        tenMatched_r;
   reg  [FILT_W-1:0] sclCnt_r;
   reg  [FILT_W-1:0] sdaCnt_r;
   reg        sclF_r;
   reg        sdaF_r;
   reg        sclD_r;
   reg        sdaD_r;
   reg        stretch_r;

   wire       enabled  = ctl_r[`SSP_CTL_EN];
   wire [3:0] mode     = ctl_r[3:0];
   wire       slave7   = (mode == `SSP_MODE_S7);
   wire       slave10  = (mode == `SSP_MODE_S10);
   wire       slaveOn  = enabled && (slave7 || slave10);
   wire       sclRise  = sclF_r && !sclD_r;
   wire       sclFall  = !sclF_r && sclD_r;
   wire       startEv  = sclF_r && sclD_r && sdaD_r && !sdaF_r;
   wire       stopEv   = sclF_r && sclD_r && !sdaD_r && sdaF_r;
   wire       acc      = psel && penable && pready;
   wire [7:0] idx      = paddr[9:2];
   wire       wr       = acc && pwrite;
   wire       rd       = acc && !pwrite;
   wire       addrWr   = wr && (idx == `SSP_IDX_ADDR);
   wire       bufRd    = rd && (idx == `SSP_IDX_BUF);
   wire       bufWr    = wr && (idx == `SSP_IDX_BUF);
   wire       hiByte   = (sr_r[7:3] == 5'b11110);
   wire       mapped   = (idx == `SSP_IDX_GIC) || (idx == `SSP_IDX_PIF) || (idx == `SSP_IDX_BUF) ||
                         (idx == `SSP_IDX_CTL) || (idx == `SSP_IDX_ADDR) || (idx == `SSP_IDX_PIE) ||
                         (idx == `SSP_IDX_STAT);

   // glitch filter: a pin level must hold for 2^FILT_W clocks
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sclCnt_r <= {FILT_W{1'b0}};
         sdaCnt_r <= {FILT_W{1'b0}};
         sclF_r   <= 1'b1;
         sdaF_r   <= 1'b1;
         sclD_r   <= 1'b1;
         sdaD_r   <= 1'b1;
      end
      else
      begin
         sclD_r <= sclF_r;
         sdaD_r <= sdaF_r;
         if (sclIn == sclF_r)
            sclCnt_r <= {FILT_W{1'b0}};
         else if (&sclCnt_r)
         begin
            sclF_r   <= sclIn;
            sclCnt_r <= {FILT_W{1'b0}};
         end
         else
            sclCnt_r <= sclCnt_r + 1'b1;
         if (sdaIn == sdaF_r)
            sdaCnt_r <= {FILT_W{1'b0}};
         else if (&sdaCnt_r)
         begin
            sdaF_r   <= sdaIn;
            sdaCnt_r <= {FILT_W{1'b0}};
         end
         else
            sdaCnt_r <= sdaCnt_r + 1'b1;
      end
   end

   // apb slave, zero wait states
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
            case (paddr[9:2])
               `SSP_IDX_GIC:  prdata <= {24'h00_0000, gic_r};
               `SSP_IDX_PIF:  prdata <= {24'h00_0000, pif_r};
               `SSP_IDX_BUF:  prdata <= {24'h00_0000, buf_r};
               `SSP_IDX_CTL:  prdata <= {24'h00_0000, ctl_r};
               `SSP_IDX_ADDR: prdata <= {24'h00_0000, addr_r};
               `SSP_IDX_PIE:  prdata <= {24'h00_0000, pie_r};
               `SSP_IDX_STAT: prdata <= {24'h00_0000, stat_r};
               default:       prdata <= 32'h0000_0000;
            endcase
      end
   end

   // software registers and hardware-set flags; flag sets win over writes, but the CKR clear and the address-write clear of stretch_r win
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ctl_r  <= `SSP_RST_CTL;
         stat_r <= `SSP_RST_STAT;
         pif_r  <= `SSP_RST_PIF;
         pie_r  <= `SSP_RST_PIE;
         gic_r  <= `SSP_RST_GIC;
         addr_r <= `SSP_RST_ADDR;
         buf_r  <= 8'h00;
         sr_r   <= 8'h00;
         st_r   <= ST_IDLE;
         bitCnt_r     <= 4'h0;
         ackOk_r      <= 1'b0;
         matched_r    <= 1'b0;
         addrPhase_r  <= 2'd0;
         tenMatched_r <= 1'b0;
         stretch_r    <= 1'b0;
      end
      else
      begin
         if (wr && idx == `SSP_IDX_CTL)
            ctl_r <= pwdata[7:0];
         if (wr && idx == `SSP_IDX_PIE)
            pie_r <= pwdata[7:0];
         if (wr && idx == `SSP_IDX_GIC)
            gic_r <= pwdata[7:0];
         if (wr && idx == `SSP_IDX_PIF)
            pif_r <= pwdata[7:0];
         if (wr && idx == `SSP_IDX_STAT)
            stat_r[7:6] <= pwdata[7:6];
         if (addrWr)
         begin
            addr_r <= pwdata[7:0];
            stat_r[`SSP_ST_UA] <= 1'b0;
            stretch_r <= 1'b0;
         end
         if (bufRd)
            stat_r[`SSP_ST_BF] <= 1'b0;
         if (bufWr)
         begin
            if (st_r == ST_RECV || st_r == ST_ACK)
               ctl_r[`SSP_CTL_WRITE_COLLISION_FLAG] <= 1'b1;
            else
            begin
               buf_r <= pwdata[7:0];
               sr_r  <= pwdata[7:0];
            end
         end
         if (!slaveOn)
         begin
            st_r      <= ST_IDLE;
            stretch_r <= 1'b0;
         end
         else
         begin
            if (startEv)
            begin
               stat_r[`SSP_ST_START] <= 1'b1;
               stat_r[`SSP_ST_STOP]  <= 1'b0;
               st_r        <= ST_RECV;
               bitCnt_r    <= 4'h0;
               matched_r   <= 1'b0;
               addrPhase_r <= 2'd0;
            end
            else if (stopEv)
            begin
               stat_r[`SSP_ST_STOP]  <= 1'b1;
               stat_r[`SSP_ST_START] <= 1'b0;
               st_r         <= ST_IDLE;
               tenMatched_r <= 1'b0;
            end
            else
               case (st_r)
                  ST_RECV:
                  begin
                     if (sclRise && bitCnt_r < 4'h8)
                     begin
                        sr_r     <= {sr_r[6:0], sdaF_r};
                        bitCnt_r <= bitCnt_r + 4'h1;
                     end
                     if (sclFall && bitCnt_r == 4'h8)
                     begin
                        st_r <= ST_ACK;
                        if (matched_r)
                           ackOk_r <= !stat_r[`SSP_ST_BF] && !ctl_r[`SSP_CTL_OV];
                        else if (slave7 && sr_r[7:1] == addr_r[7:1])
                        begin
                           ackOk_r <= !stat_r[`SSP_ST_BF] && !ctl_r[`SSP_CTL_OV];
                           stat_r[`SSP_ST_RW] <= sr_r[0];
                        end
                        else if (slave10 && addrPhase_r == 2'd0 && hiByte && sr_r[7:1] == addr_r[7:1])
                        begin
                           ackOk_r <= !stat_r[`SSP_ST_BF] && !ctl_r[`SSP_CTL_OV];
                           stat_r[`SSP_ST_RW] <= sr_r[0];
                           if (!tenMatched_r && !sr_r[0])
                              stat_r[`SSP_ST_UA] <= 1'b1;
                        end
                        else if (slave10 && addrPhase_r == 2'd1 && sr_r == addr_r)
                        begin
                           ackOk_r <= !stat_r[`SSP_ST_BF] && !ctl_r[`SSP_CTL_OV];
                           stat_r[`SSP_ST_UA] <= 1'b1;
                        end
                        else
                        begin
                           ackOk_r <= 1'b0;
                           st_r    <= ST_IDLE;
                        end
                        if (matched_r || slave7 && sr_r[7:1] == addr_r[7:1] ||
                            slave10 && ((addrPhase_r == 2'd0 && hiByte && sr_r[7:1] == addr_r[7:1]) ||
                                        (addrPhase_r == 2'd1 && sr_r == addr_r)))
                        begin
                           if (stat_r[`SSP_ST_BF])
                              ctl_r[`SSP_CTL_OV] <= 1'b1;
                           else
                           begin
                              buf_r <= sr_r;
                              stat_r[`SSP_ST_BF] <= 1'b1;
                           end
                           stat_r[`SSP_ST_DA] <= matched_r;
                        end
                     end
                  end
                  ST_ACK:
                  begin
                     if (sclFall)
                     begin
                        pif_r[`SSP_PIF_PORT] <= 1'b1;
                        bitCnt_r <= 4'h0;
                        // hold only after the ack bit, else the master never sees it
                        if (stat_r[`SSP_ST_UA] && ackOk_r && !addrWr)
                           stretch_r <= 1'b1;
                        // a refused data byte keeps the link; refused address drops it
                        if (!ackOk_r && !matched_r)
                           st_r <= ST_IDLE;
                        else if (matched_r || !slave10 || addrPhase_r == 2'd1 || tenMatched_r)
                        begin
                           matched_r    <= 1'b1;
                           tenMatched_r <= slave10;
                           if (stat_r[`SSP_ST_RW])
                           begin
                              st_r <= ST_SEND;
                              ctl_r[`SSP_CTL_CKR] <= 1'b0;
                           end
                           else
                              st_r <= ST_RECV;
                        end
                        else
                        begin
                           addrPhase_r <= 2'd1;
                           st_r <= ST_RECV;
                        end
                     end
                  end
                  ST_SEND:
                  begin
                     if (sclFall && ctl_r[`SSP_CTL_CKR])
                     begin
                        if (bitCnt_r == 4'h7)
                           st_r <= ST_MACK;
                        else
                           sr_r <= {sr_r[6:0], 1'b0};
                        bitCnt_r <= bitCnt_r + 4'h1;
                     end
                  end
                  ST_MACK:
                  begin
                     if (sclRise && sdaF_r)
                        st_r <= ST_IDLE;
                     else if (sclFall)
                     begin
                        pif_r[`SSP_PIF_PORT] <= 1'b1;
                        ctl_r[`SSP_CTL_CKR] <= 1'b0;
                        bitCnt_r <= 4'h0;
                        st_r <= ST_SEND;
                     end
                  end
                  default: st_r <= ST_IDLE;
               endcase
         end
      end
   end

   // pin drivers: open drain, enable means pull low
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sclOut      <= 1'b0;
         sclOe       <= 1'b0;
         sdaOut      <= 1'b0;
         sdaOe       <= 1'b0;
         smbusLevels <= 1'b0;
         portIrq     <= 1'b0;
      end
      else
      begin
         sclOut      <= 1'b0;
         sdaOut      <= 1'b0;
         smbusLevels <= stat_r[`SSP_ST_LVL];
         portIrq     <= pif_r[`SSP_PIF_PORT] && pie_r[`SSP_PIF_PORT];
         if (!slaveOn)
         begin
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
         end
         else
         begin
            // hold clock low after the 9th fall while stretching
            sclOe <= !sclF_r && (stretch_r || (st_r == ST_SEND && !ctl_r[`SSP_CTL_CKR]));
            if (st_r == ST_ACK)
               sdaOe <= ackOk_r;
            else if (st_r == ST_SEND)
               sdaOe <= !sr_r[7];
            else
               sdaOe <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// >>> ssp_map.vh
`ifndef SSP_MAP_VH
`define SSP_MAP_VH
// register indices (printed offsets); byte address is index * 4
`define SSP_IDX_GIC      8'h0b
`define SSP_IDX_PIF      8'h0c
`define SSP_IDX_BUF      8'h13
`define SSP_IDX_CTL      8'h14
`define SSP_IDX_ADDR     8'h15
`define SSP_IDX_PIE      8'h8c
`define SSP_IDX_STAT     8'h94
// control fields
`define SSP_CTL_WRITE_COLLISION_FLAG     7
`define SSP_CTL_OV       6
`define SSP_CTL_EN       5
`define SSP_CTL_CKR      4
// status fields
`define SSP_ST_SMP       7
`define SSP_ST_LVL       6
`define SSP_ST_DA        5
`define SSP_ST_STOP      4
`define SSP_ST_START     3
`define SSP_ST_RW        2
`define SSP_ST_UA        1
`define SSP_ST_BF        0
// interrupt flag position
`define SSP_PIF_PORT     3
// mode codes
`define SSP_MODE_S7      4'h6
`define SSP_MODE_S10     4'h7
`define SSP_MODE_MST     4'h8
// reset values
`define SSP_RST_CTL      8'h00
`define SSP_RST_STAT     8'h00
`define SSP_RST_PIF      8'h00
`define SSP_RST_PIE      8'h00
`define SSP_RST_GIC      8'h00
`define SSP_RST_ADDR     8'h00
// glitch filter terminal count (depth in clocks minus one)
`define SSP_FILT_CNT     2'h3
`endif

// >>> ssp_slave_checker.sv
`include "ssp_map.vh"
`default_nettype none
module ssp_slave_checker #(
   parameter FILT_W = 2
) (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sclIn,
   input wire logic        sclOut,
   input wire logic        sclOe,
   input wire logic        sdaIn,
   input wire logic        sdaOut,
   input wire logic        sdaOe,
   input wire logic        smbusLevels,
   input wire logic        portIrq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] idx;
   logic       wrTake;
   logic       addrWr;
   logic       mapped;
   logic       portAct;
   logic [5:0] ctl_r;
   logic       pie_r;
   logic       lvl_r;
   assign idx     = paddr[9:2];
   assign wrTake  = psel && penable && pready && pwrite;
   assign addrWr  = wrTake && (idx == `SSP_IDX_ADDR);
   assign mapped  = idx inside {`SSP_IDX_GIC, `SSP_IDX_PIF, `SSP_IDX_BUF, `SSP_IDX_CTL, `SSP_IDX_ADDR,
                                `SSP_IDX_PIE, `SSP_IDX_STAT};
   assign portAct = ctl_r[5] && (ctl_r[3:0] == `SSP_MODE_S7 || ctl_r[3:0] == `SSP_MODE_S10);
   // shadow of software settings, taken only from completed writes
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ctl_r <= 6'h00;
         pie_r <= 1'b0;
         lvl_r <= 1'b0;
      end
      else if (wrTake)
      begin
         if (idx == `SSP_IDX_CTL) ctl_r <= pwdata[5:0];
         if (idx == `SSP_IDX_PIE) pie_r <= pwdata[3];
         if (idx == `SSP_IDX_STAT) lvl_r <= pwdata[6];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_once; pready |=> !pready; endproperty
   a_once: assert property (p_once) else $error("ready longer than one cycle");
   property p_slverr; psel && !penable && !mapped |=> pslverr; endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
   property p_idle; !portAct && !$past(portAct) |-> !sdaOe && !sclOe; endproperty
   a_idle: assert property (p_idle) else $error("pins driven while idle");
   property p_irq; portIrq |-> $past(pie_r); endproperty
   a_irq: assert property (p_irq) else $error("irq without enable");
   property p_levels; $changed(lvl_r) |-> ##[0:1] (smbusLevels == lvl_r); endproperty
   a_levels: assert property (p_levels) else $error("threshold select not applied");
   property p_ack_len; $rose(sdaOe) |-> ##[1:100] !sdaOe; endproperty
   a_ack_len: assert property (p_ack_len) else $error("ack held too long");
   property p_ack_low; $changed(sdaOe) |-> !sclIn; endproperty
   a_ack_low: assert property (p_ack_low) else $error("data moved with clock high");
   property p_hold_low; $rose(sclOe) |-> !$past(sclIn); endproperty
   a_hold_low: assert property (p_hold_low) else $error("clock grabbed while high");
   property p_release; sclOe && addrWr |-> ##[1:3] !sclOe; endproperty
   a_release: assert property (p_release) else $error("clock not released");
   c_ack: cover property ($rose(sdaOe));
   c_hold: cover property ($rose(sclOe));
   c_err: cover property (pslverr);
endmodule
bind ssp_slave ssp_slave_checker #(.FILT_W(FILT_W)) chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe, .smbusLevels, .portIrq);
`default_nettype wire

// >>> ssp_i2c_master.sv
`default_nettype none
module ssp_i2c_master (
   input  wire logic ref_clk,
   input  wire logic sclLine,
   input  wire logic sdaLine,
   output var logic  sclDrv,
   output var logic  sdaDrv
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 12;
   initial sclDrv = 1'b1;
   initial sdaDrv = 1'b1;
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // slave may stretch; the bench watchdog bounds a stuck clock
   task automatic put(input logic b);
      hold(HALF / 2);
      sdaDrv <= b;
      hold(HALF / 2);
      sclDrv <= 1'b1;
      hold(1);
      while (!sclLine) hold(1);
      hold(HALF);
   endtask
   task automatic start();
      put(1'b1);
      sdaDrv <= 1'b0;
      hold(HALF);
      sclDrv <= 1'b0;
   endtask
   task automatic stop();
      put(1'b0);
      sdaDrv <= 1'b1;
      hold(HALF);
   endtask
   task automatic sendByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         put(b[i]);
         sclDrv <= 1'b0;
      end
      put(1'b1);
      ack = !sdaLine;
      sclDrv <= 1'b0;
   endtask
   // reads one byte from the slave and answers with a not-ack
   task automatic readByte(output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         put(1'b1);
         b[i] = sdaLine;
         sclDrv <= 1'b0;
      end
      put(1'b1);
      sclDrv <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> i2c_slave_address_receive_bench.sv
`include "ssp_map.vh"
`default_nettype none
module i2c_slave_address_receive_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [7:0]  rdByte;
   logic        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, smbusLevels, portIrq, mScl, mSda, ack, lastErr;
   wire logic   sclLine = mScl & ~sclOe;
   wire logic   sdaLine = mSda & ~sdaOe;
   int          error_cnt = 0;
   int          compares  = 0;
   always #50 ref_clk = ~ref_clk;
   ssp_slave #(.FILT_W(2)) dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .sclIn(sclLine), .sclOut, .sclOe, .sdaIn(sdaLine), .sdaOut, .sdaOe, .smbusLevels, .portIrq);
   ssp_i2c_master m (.ref_clk, .sclLine, .sdaLine, .sclDrv(mScl), .sdaDrv(mSda));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {2'b00, idx, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd      = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rbyte(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      check($sformatf("reg %h", idx), rd, {24'h00_0000, exp});
   endtask
   task automatic rbit(input logic [7:0] idx, input int n, input logic exp);
      apb(1'b0, idx, 8'h00);
      check($sformatf("reg %h bit %0d", idx, n), rd[n], exp);
   endtask
   task automatic xfer(input logic [7:0] b, input logic exp);
      m.sendByte(b, ack);
      check("ack", ack, exp);
   endtask
   task automatic frame(input logic [7:0] b, input logic exp);
      m.start();
      xfer(b, exp);
      m.stop();
   endtask
   // clock hold is sampled after the input filter has seen the fall
   task automatic held(input logic exp);
      repeat (10) @(posedge ref_clk);
      check("clock hold", sclOe, exp);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      $display("watchdog expired");
      tally_and_finish();
   end
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rbyte(`SSP_IDX_CTL, `SSP_RST_CTL);
      rbyte(`SSP_IDX_STAT, `SSP_RST_STAT);
      rbyte(`SSP_IDX_PIF, `SSP_RST_PIF);
      rbyte(`SSP_IDX_PIE, `SSP_RST_PIE);
      rbyte(`SSP_IDX_GIC, `SSP_RST_GIC);
      rbyte(8'h20, 8'h00);
      check("slverr", lastErr, 1'b1);
      $display("test registers done");
      apb(1'b1, `SSP_IDX_ADDR, 8'hA4);
      apb(1'b1, `SSP_IDX_CTL, 8'h10 | `SSP_MODE_S7);
      frame(8'hA4, 1'b0);
      apb(1'b1, `SSP_IDX_CTL, 8'h30 | `SSP_MODE_MST);
      frame(8'hA4, 1'b0);
      apb(1'b1, `SSP_IDX_CTL, 8'h30 | `SSP_MODE_S7);
      frame(8'hA4, 1'b1);
      frame(8'hA6, 1'b0);
      rbit(`SSP_IDX_STAT, `SSP_ST_BF, 1'b1);
      rbit(`SSP_IDX_PIF, `SSP_PIF_PORT, 1'b1);
      apb(1'b1, `SSP_IDX_PIE, 8'h08);
      @(posedge ref_clk);
      check("irq", portIrq, 1'b1);
      apb(1'b1, `SSP_IDX_PIE, 8'h00);
      @(posedge ref_clk);
      check("irq", portIrq, 1'b0);
      apb(1'b1, `SSP_IDX_PIF, 8'h00);
      rbyte(`SSP_IDX_BUF, 8'hA4);
      rbit(`SSP_IDX_STAT, `SSP_ST_BF, 1'b0);
      $display("test modes done");
      m.start();
      xfer(8'hA4, 1'b1);
      rbit(`SSP_IDX_STAT, `SSP_ST_START, 1'b1);
      apb(1'b0, `SSP_IDX_BUF, 8'h00);
      xfer(8'h3C, 1'b1);
      rbit(`SSP_IDX_STAT, `SSP_ST_DA, 1'b1);
      apb(1'b1, `SSP_IDX_PIF, 8'h00);
      xfer(8'h5A, 1'b0);
      rbit(`SSP_IDX_CTL, `SSP_CTL_OV, 1'b1);
      rbit(`SSP_IDX_PIF, `SSP_PIF_PORT, 1'b1);
      rbyte(`SSP_IDX_BUF, 8'h3C);
      xfer(8'h77, 1'b0);
      rbyte(`SSP_IDX_BUF, 8'h77);
      apb(1'b1, `SSP_IDX_CTL, 8'h30 | `SSP_MODE_S7);
      rbit(`SSP_IDX_CTL, `SSP_CTL_OV, 1'b0);
      xfer(8'h11, 1'b1);
      m.stop();
      rbit(`SSP_IDX_STAT, `SSP_ST_STOP, 1'b1);
      rbyte(`SSP_IDX_BUF, 8'h11);
      apb(1'b1, `SSP_IDX_STAT, 8'h40);
      @(posedge ref_clk);
      check("levels", smbusLevels, 1'b1);
      apb(1'b1, `SSP_IDX_STAT, 8'h00);
      @(posedge ref_clk);
      check("levels", smbusLevels, 1'b0);
      $display("test receive done");
      m.start();
      xfer(8'hA5, 1'b1);
      // master stalls on the held clock while software loads the byte
      fork
         m.readByte(rdByte);
         begin
            held(1'b1);
            check("drive levels", {sclOut, sdaOut}, 32'h0000_0000);
            rbyte(`SSP_IDX_BUF, 8'hA5);
            apb(1'b1, `SSP_IDX_BUF, 8'hB5);
            apb(1'b1, `SSP_IDX_CTL, 8'h30 | `SSP_MODE_S7);
         end
      join
      check("sent byte", rdByte, {24'h00_0000, 8'hB5});
      m.stop();
      rbit(`SSP_IDX_STAT, `SSP_ST_RW, 1'b1);
      $display("test transmit done");
      apb(1'b1, `SSP_IDX_ADDR, 8'hF2);
      apb(1'b1, `SSP_IDX_CTL, 8'h30 | `SSP_MODE_S10);
      m.start();
      xfer(8'hF2, 1'b1);
      held(1'b1);
      rbit(`SSP_IDX_STAT, `SSP_ST_UA, 1'b1);
      apb(1'b1, `SSP_IDX_ADDR, 8'h5A);
      repeat (2) @(posedge ref_clk);
      check("clock hold", sclOe, 1'b0);
      rbit(`SSP_IDX_STAT, `SSP_ST_UA, 1'b0);
      rbyte(`SSP_IDX_BUF, 8'hF2);
      xfer(8'h5A, 1'b1);
      held(1'b1);
      rbit(`SSP_IDX_STAT, `SSP_ST_UA, 1'b1);
      apb(1'b1, `SSP_IDX_ADDR, 8'hF2);
      repeat (2) @(posedge ref_clk);
      check("clock hold", sclOe, 1'b0);
      rbyte(`SSP_IDX_BUF, 8'h5A);
      xfer(8'h99, 1'b1);
      m.stop();
      rbyte(`SSP_IDX_BUF, 8'h99);
      $display("test ten bit done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
